// file: rtl/rup_defines.svh
`ifndef RUP_DEFINES_SVH
`define RUP_DEFINES_SVH

// Field widths of the status words and the control layout.
`define RUP_STATE_W        2
`define RUP_PAD_W          6
`define RUP_BOOT_W         24
`define RUP_BOOT_HI_W      22
`define RUP_BOOT_LO_W      2
`define RUP_DOG_HI_W       12
`define RUP_DOG_LO_W       17
`define RUP_SRC_W          5
`define RUP_WORD_W         32
`define RUP_PREV_W         31
`define RUP_CTRL_W         39

// Constant pieces appended to the register fields.
`define RUP_BOOT_LO        2'h0
`define RUP_PAD_ZERO       6'h00
`define RUP_DOG_LO         17'h00008
`define RUP_WORD_PAD       7'h00
`define RUP_PREV_PAD       8'h00

// One-hot cause positions inside the five-bit source field.
`define RUP_SRC_EXT_RESET  4
`define RUP_SRC_CRC        3
`define RUP_SRC_ERR_PIN    2
`define RUP_SRC_WATCHDOG   1
`define RUP_SRC_FABRIC     0
`define RUP_SRC_NONE       5'h00
`define RUP_SRC_FABRIC_OH  5'h01

// Reset values and the marker shifted out for a capture of an unrecorded previous state or an unused select.
`define RUP_CTRL_RESET     39'h00_0000_0000
`define RUP_BAD_CAPTURE    39'h7f_ffff_ffff
`define RUP_PIN_SYNC_RESET 3'h3
`define RUP_RST_PIPE_ON    2'h3
`define RUP_RST_PIPE_OFF   2'h0

// Pin synchroniser lanes.
`define RUP_PIN_EXT_RESET  0
`define RUP_PIN_ERR        1
`define RUP_PIN_FABRIC     2
`define RUP_PIN_N          3

`endif

// file: rtl/rup_pkg.sv
package rup_pkg;
`include "rup_defines.svh"

	typedef struct packed {
		logic [`RUP_DOG_HI_W-1:0]  watchdog_timer;
		logic [`RUP_BOOT_HI_W-1:0] boot_addr_hi;
		logic                      rsv1;
		logic                      watchdog_enable;
		logic                      osc_int;
		logic                      early_done_check_option;
		logic                      rsv2;
	} rup_ctrl_type;

	typedef struct packed {
		logic [`RUP_SRC_W-1:0]   source;
		logic [`RUP_STATE_W-1:0] state;
		logic [`RUP_BOOT_W-1:0]  boot_addr;
	} rup_prev_type;

	typedef struct packed {
		logic                     factory;
		logic                     prev1_valid;
		logic                     prev2_valid;
		rup_ctrl_type             ctrl;
		logic [`RUP_WORD_W-1:0]   info1;
		logic [`RUP_WORD_W-1:0]   info2;
		rup_prev_type             prev1;
		rup_prev_type             prev2;
	} rup_view_type;

	typedef enum logic [2:0] {
		RUP_SEL_INFO1  = 3'h0,
		RUP_SEL_INFO2  = 3'h1,
		RUP_SEL_PREV1  = 3'h2,
		RUP_SEL_PREV2  = 3'h3,
		RUP_SEL_CONFIG = 3'h4
	} rup_capsel_type;

	typedef enum logic [3:0] {
		RUP_ST_IDLE   = 4'h1,
		RUP_ST_RECORD = 4'h2,
		RUP_ST_LOAD   = 4'h4,
		RUP_ST_WAIT   = 4'h8
	} rup_state_type;

endpackage : rup_pkg

// file: rtl/rup_word_xfer.sv
`timescale 1ns/1ns
// Four-phase-free toggle handshake carrying a whole word between two clocks.
// The source reloads its holding register only after the previous toggle has
// been acknowledged, so the word is stable whenever the far side samples it.
module rup_word_xfer #(
	parameter int W = 8
) (
	input  wire logic         src_clk,
	input  wire logic         src_rst_n,
	input  wire logic [W-1:0] src_data,
	input  wire logic         dst_clk,
	input  wire logic         dst_rst_n,
	input  wire logic [W-1:0] dst_reset_value,
	output logic      [W-1:0] dst_data
);

	generate
		if (W < 1)
		begin : g_bad_width
			$error("rup_word_xfer needs a width of at least one bit");
		end
	endgenerate

	logic [W-1:0] hold_q;
	logic [W-1:0] hold_d;
	logic         req_q;
	logic         req_d;
	logic         ack_s1_q;
	logic         ack_s2_q;
	logic         req_s1_q;
	logic         req_s2_q;
	logic         ack_q;
	logic         ack_d;
	logic [W-1:0] dst_q;
	logic [W-1:0] dst_d;
	logic         dst_loaded_q;

	always_comb
	begin
		hold_d = hold_q;
		req_d  = req_q;
		if (ack_s2_q == req_q)
		begin
			hold_d = src_data;
			req_d  = ~req_q;
		end
	end

	always_ff @(posedge src_clk or negedge src_rst_n)
	begin
		if (!src_rst_n)
		begin
			hold_q   <= '0;
			req_q    <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end
		else
		begin
			hold_q   <= hold_d;
			req_q    <= req_d;
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	always_comb
	begin
		ack_d = ack_q;
		dst_d = dst_q;
		if (!dst_loaded_q)
			dst_d = dst_reset_value;
		if (req_s2_q != ack_q)
		begin
			dst_d = hold_q;
			ack_d = req_s2_q;
		end
	end

	always_ff @(posedge dst_clk or negedge dst_rst_n)
	begin
		if (!dst_rst_n)
		begin
			req_s1_q     <= 1'b0;
			req_s2_q     <= 1'b0;
			ack_q        <= 1'b0;
			dst_q        <= '0;
			dst_loaded_q <= 1'b0;
		end
		else
		begin
			req_s1_q     <= req_q;
			req_s2_q     <= req_s1_q;
			ack_q        <= ack_d;
			dst_q        <= dst_d;
			dst_loaded_q <= 1'b1;
		end
	end

	assign dst_data = dst_q;

endmodule : rup_word_xfer

// file: rtl/rup_status_core.sv
`timescale 1ns/1ns
`include "rup_defines.svh"

module rup_status_core
	import rup_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	input  wire logic                      upgrade_shift_clock,
	input  wire logic                      external_config_reset_pin_n,
	input  wire logic                      config_error_pin_n,
	input  wire logic                      crc_error_evt,
	input  wire logic                      watchdog_timeout_evt,
	input  wire logic                      load_done,
	input  wire logic [`RUP_STATE_W-1:0]   msm_state,
	input  wire logic [`RUP_BOOT_W-1:0]    factory_boot_addr,
	input  wire logic                      fabric_reconfig_request,
	input  wire logic                      shift_enable,
	input  wire logic                      capture_request,
	input  wire logic                      update_request,
	input  wire rup_capsel_type            capture_select,
	input  wire logic                      shift_data_in,
	output logic                           shift_data_out,
	output rup_ctrl_type                   control_out,
	output logic                           reconfig_start,
	output logic                           app_mode,
	output logic [`RUP_SRC_W-1:0]          last_cause
);

	// Highest set position only; the field stays one-hot.
	function automatic logic [`RUP_SRC_W-1:0] rup_pick_cause(input logic [`RUP_SRC_W-1:0] v);
		logic [`RUP_SRC_W-1:0] r;
		r = `RUP_SRC_NONE;
		for (int i = 0; i < `RUP_SRC_W; i++)
		begin
			if (v[i])
				r = `RUP_SRC_W'(1) << i;
		end
		return r;
	endfunction : rup_pick_cause

	// Reset release, one copy per clock domain.
	logic [1:0] sys_rst_pipe_q;
	logic [1:0] sys_rst_pipe_d;
	logic [1:0] link_rst_pipe_q;
	logic [1:0] link_rst_pipe_d;
	logic       sys_rst_n;
	logic       link_rst_n;

	always_comb
	begin
		sys_rst_pipe_d  = {sys_rst_pipe_q[0], 1'b1};
		link_rst_pipe_d = {link_rst_pipe_q[0], 1'b1};
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sys_rst_pipe_q <= `RUP_RST_PIPE_OFF;
		else
			sys_rst_pipe_q <= sys_rst_pipe_d;
	end

	always_ff @(posedge upgrade_shift_clock or negedge arst_n)
	begin
		if (!arst_n)
			link_rst_pipe_q <= `RUP_RST_PIPE_OFF;
		else
			link_rst_pipe_q <= link_rst_pipe_d;
	end

	assign sys_rst_n  = sys_rst_pipe_q[1];
	assign link_rst_n = link_rst_pipe_q[1];

	// Pins and the fabric request come from other clocks; two flops each.
	logic [`RUP_PIN_N-1:0] pin_s1_q;
	logic [`RUP_PIN_N-1:0] pin_s2_q;
	logic [`RUP_PIN_N-1:0] pin_last_q;
	logic [`RUP_PIN_N-1:0] pin_raw;

	assign pin_raw = {fabric_reconfig_request, config_error_pin_n, external_config_reset_pin_n};

	always_ff @(posedge sys_clk or negedge sys_rst_n)
	begin
		if (!sys_rst_n)
		begin
			pin_s1_q   <= `RUP_PIN_SYNC_RESET;
			pin_s2_q   <= `RUP_PIN_SYNC_RESET;
			pin_last_q <= `RUP_PIN_SYNC_RESET;
		end
		else
		begin
			pin_s1_q   <= pin_raw;
			pin_s2_q   <= pin_s1_q;
			pin_last_q <= pin_s2_q;
		end
	end

	// Cause vector in record bit order.
	logic [`RUP_SRC_W-1:0] src_vec;

	always_comb
	begin
		src_vec = `RUP_SRC_NONE;
		src_vec[`RUP_SRC_EXT_RESET] = pin_last_q[`RUP_PIN_EXT_RESET]
			& ~pin_s2_q[`RUP_PIN_EXT_RESET];
		src_vec[`RUP_SRC_CRC]       = crc_error_evt;
		src_vec[`RUP_SRC_ERR_PIN]   = pin_last_q[`RUP_PIN_ERR] & ~pin_s2_q[`RUP_PIN_ERR];
		src_vec[`RUP_SRC_WATCHDOG]  = watchdog_timeout_evt;
		src_vec[`RUP_SRC_FABRIC]    = pin_s2_q[`RUP_PIN_FABRIC]
			& ~pin_last_q[`RUP_PIN_FABRIC];
	end

	// Control, status and reconfiguration sequencing on the internal clock.
	rup_state_type         state_q;
	rup_state_type         state_d;
	rup_ctrl_type          ctrl_q;
	rup_ctrl_type          ctrl_d;
	rup_ctrl_type          update_sys;
	rup_prev_type          prev1_q;
	rup_prev_type          prev1_d;
	rup_prev_type          prev2_q;
	rup_prev_type          prev2_d;
	logic                  prev1_valid_q;
	logic                  prev1_valid_d;
	logic                  prev2_valid_q;
	logic                  prev2_valid_d;
	logic [`RUP_SRC_W-1:0] cause_q;
	logic [`RUP_SRC_W-1:0] cause_d;
	logic                  factory_q;
	logic                  factory_d;
	logic                  next_factory_q;
	logic                  next_factory_d;
	logic                  start_q;
	logic                  start_d;
	logic                  app_q;
	logic                  app_d;
	logic [`RUP_BOOT_W-1:0] cur_boot;

	always_comb
	begin
		if (factory_q)
			cur_boot = factory_boot_addr;
		else
			cur_boot = {ctrl_q.boot_addr_hi, `RUP_BOOT_LO};
	end

	always_comb
	begin
		state_d        = state_q;
		ctrl_d         = ctrl_q;
		prev1_d        = prev1_q;
		prev2_d        = prev2_q;
		prev1_valid_d  = prev1_valid_q;
		prev2_valid_d  = prev2_valid_q;
		cause_d        = cause_q;
		factory_d      = factory_q;
		next_factory_d = next_factory_q;
		start_d        = 1'b0;
		unique case (state_q)
			RUP_ST_IDLE, RUP_ST_WAIT:
			begin
				if (|src_vec)
				begin
					// Status is written here, ahead of any control change or load.
					cause_d = rup_pick_cause(src_vec);
					if (!factory_q)
					begin
						prev2_d       = prev1_q;
						prev2_valid_d = prev1_valid_q;
						prev1_d       = {rup_pick_cause(src_vec), msm_state, cur_boot};
						prev1_valid_d = 1'b1;
					end
					state_d = RUP_ST_RECORD;
				end
				else if (state_q == RUP_ST_WAIT && load_done)
				begin
					factory_d = next_factory_q;
					state_d   = RUP_ST_IDLE;
				end
			end
			RUP_ST_RECORD:
			begin
				if (cause_q == `RUP_SRC_FABRIC_OH)
				begin
					ctrl_d         = update_sys;
					next_factory_d = 1'b0;
				end
				else
				begin
					ctrl_d         = `RUP_CTRL_RESET;
					next_factory_d = 1'b1;
				end
				state_d = RUP_ST_LOAD;
			end
			RUP_ST_LOAD:
			begin
				start_d = 1'b1;
				state_d = RUP_ST_WAIT;
			end
		endcase
		app_d = ~factory_d;
	end

	always_ff @(posedge sys_clk or negedge sys_rst_n)
	begin
		if (!sys_rst_n)
		begin
			state_q        <= RUP_ST_IDLE;
			ctrl_q         <= `RUP_CTRL_RESET;
			prev1_q        <= '0;
			prev2_q        <= '0;
			prev1_valid_q  <= 1'b0;
			prev2_valid_q  <= 1'b0;
			cause_q        <= `RUP_SRC_NONE;
			factory_q      <= 1'b1;
			next_factory_q <= 1'b1;
			start_q        <= 1'b0;
			app_q          <= 1'b0;
		end
		else
		begin
			state_q        <= state_d;
			ctrl_q         <= ctrl_d;
			prev1_q        <= prev1_d;
			prev2_q        <= prev2_d;
			prev1_valid_q  <= prev1_valid_d;
			prev2_valid_q  <= prev2_valid_d;
			cause_q        <= cause_d;
			factory_q      <= factory_d;
			next_factory_q <= next_factory_d;
			start_q        <= start_d;
			app_q          <= app_d;
		end
	end

	// Status view offered to the shift side.
	rup_view_type view_sys;
	rup_view_type view_link;
	rup_view_type view_reset;

	always_comb
	begin
		view_sys.factory     = factory_q;
		view_sys.prev1_valid = prev1_valid_q;
		view_sys.prev2_valid = prev2_valid_q;
		view_sys.ctrl        = ctrl_q;
		view_sys.prev1       = prev1_q;
		view_sys.prev2       = prev2_q;
		view_sys.info2       = {msm_state, `RUP_PAD_ZERO, cur_boot};
		if (factory_q)
			view_sys.info1 = {msm_state, `RUP_PAD_ZERO, cur_boot};
		else
			view_sys.info1 = {msm_state, ctrl_q.watchdog_enable, ctrl_q.watchdog_timer,
				`RUP_DOG_LO};
	end

	always_comb
	begin
		view_reset         = '0;
		view_reset.factory = 1'b1;
	end

	// Words cross by handshake; the link clock may stop, so nothing waits on it.
	rup_word_xfer #(
		.W($bits(rup_view_type))
	) u_view_xfer (
		.src_clk         (sys_clk),
		.src_rst_n       (sys_rst_n),
		.src_data        (view_sys),
		.dst_clk         (upgrade_shift_clock),
		.dst_rst_n       (link_rst_n),
		.dst_reset_value (view_reset),
		.dst_data        (view_link)
	);

	// Shift and update registers on the user shift clock.
	logic [`RUP_CTRL_W-1:0] shift_q;
	logic [`RUP_CTRL_W-1:0] shift_d;
	rup_ctrl_type           update_q;
	rup_ctrl_type           update_d;

	always_comb
	begin
		shift_d  = shift_q;
		update_d = update_q;
		if (shift_enable)
			shift_d = {shift_data_in, shift_q[`RUP_CTRL_W-1:1]};
		else if (capture_request)
		begin
			unique case (capture_select)
				RUP_SEL_INFO1:
					shift_d = {`RUP_WORD_PAD, view_link.info1};
				RUP_SEL_INFO2:
					shift_d = {`RUP_WORD_PAD, view_link.info2};
				RUP_SEL_PREV1:
					shift_d = view_link.prev1_valid ? {`RUP_PREV_PAD, view_link.prev1}
						: `RUP_BAD_CAPTURE;
				RUP_SEL_PREV2:
					shift_d = view_link.prev2_valid ? {`RUP_PREV_PAD, view_link.prev2}
						: `RUP_BAD_CAPTURE;
				RUP_SEL_CONFIG:
					shift_d = view_link.factory ? update_q : view_link.ctrl;
				default:
					shift_d = `RUP_BAD_CAPTURE;
			endcase
		end
		else if (update_request && view_link.factory)
			update_d = shift_q;
	end

	always_ff @(posedge upgrade_shift_clock or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			shift_q  <= '0;
			update_q <= `RUP_CTRL_RESET;
		end
		else
		begin
			shift_q  <= shift_d;
			update_q <= update_d;
		end
	end

	// Update register back to the internal clock for the control load.
	rup_word_xfer #(
		.W($bits(rup_ctrl_type))
	) u_update_xfer (
		.src_clk         (upgrade_shift_clock),
		.src_rst_n       (link_rst_n),
		.src_data        (update_q),
		.dst_clk         (sys_clk),
		.dst_rst_n       (sys_rst_n),
		.dst_reset_value (`RUP_CTRL_RESET),
		.dst_data        (update_sys)
	);

	assign shift_data_out = shift_q[0];
	assign control_out    = ctrl_q;
	assign reconfig_start = start_q;
	assign app_mode       = app_q;
	assign last_cause     = cause_q;

endmodule : rup_status_core

// file: testbench/rup_status_core_checker.sv
`timescale 1ns/1ns
`include "rup_defines.svh"

module rup_status_core_checker
	import rup_pkg::*;
(
	input wire logic                  sys_clk,
	input wire logic                  arst_n,
	input wire logic                  upgrade_shift_clock,
	input wire logic                  crc_error_evt,
	input wire logic                  watchdog_timeout_evt,
	input wire logic                  shift_enable,
	input wire logic                  capture_request,
	input wire logic                  shift_data_out,
	input wire rup_ctrl_type          control_out,
	input wire logic                  reconfig_start,
	input wire logic [`RUP_SRC_W-1:0] last_cause
);
	// Record and load steps sit between two starts, so quiet cycles follow each pulse.
	sequence s_pulse;
		reconfig_start ##1 !reconfig_start ##1 !reconfig_start;
	endsequence
	property p_start_pulse;
		@(posedge sys_clk) disable iff (!arst_n) reconfig_start |-> s_pulse;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
	property p_cause_onehot;
		@(posedge sys_clk) disable iff (!arst_n) $onehot0(last_cause);
	endproperty
	a_cause_onehot: assert property (p_cause_onehot) else $error("cause not one-hot");
	property p_crc_src;
		@(posedge sys_clk) disable iff (!arst_n)
		reconfig_start && last_cause == 5'h08 |-> $past(crc_error_evt, 3);
	endproperty
	a_crc_src: assert property (p_crc_src) else $error("crc cause without crc event");
	property p_dog_src;
		@(posedge sys_clk) disable iff (!arst_n) reconfig_start && last_cause == 5'h02
		|-> $past(watchdog_timeout_evt, 3) && !$past(crc_error_evt, 3);
	endproperty
	a_dog_src: assert property (p_dog_src) else $error("watchdog cause wrongly ranked");
	property p_clear;
		@(posedge sys_clk) disable iff (!arst_n)
		reconfig_start && !last_cause[0] |-> control_out == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("control not cleared");
	property p_record_first;
		@(posedge sys_clk) disable iff (!arst_n)
		reconfig_start |-> last_cause != 5'h00 && last_cause == $past(last_cause, 2);
	endproperty
	a_record_first: assert property (p_record_first) else $error("status late");
	property p_ctrl_moves;
		@(posedge sys_clk) disable iff (!arst_n) $changed(control_out) |=> reconfig_start;
	endproperty
	a_ctrl_moves: assert property (p_ctrl_moves) else $error("control moved alone");
	property p_shift_hold;
		@(posedge upgrade_shift_clock) disable iff (!arst_n)
		!shift_enable && !capture_request |=> $stable(shift_data_out);
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("serial out moved");
endmodule : rup_status_core_checker

bind rup_status_core rup_status_core_checker u_checker (.sys_clk, .arst_n,
	.upgrade_shift_clock, .crc_error_evt, .watchdog_timeout_evt, .shift_enable,
	.capture_request, .shift_data_out, .control_out, .reconfig_start, .last_cause);

// file: testbench/rup_user_model.sv
`timescale 1ns/1ns
`include "rup_defines.svh"

// Fabric user logic. Its shift clock runs only inside a frame.
module rup_user_model
	import rup_pkg::*;
(
	output logic           upgrade_shift_clock,
	output logic           shift_enable,
	output logic           capture_request,
	output logic           update_request,
	output rup_capsel_type capture_select,
	output logic           shift_data_in,
	output logic           fabric_reconfig_request,
	input  wire logic      shift_data_out
);
	initial
	begin
		upgrade_shift_clock     = 1'b0;
		shift_enable            = 1'b0;
		capture_request         = 1'b0;
		update_request          = 1'b0;
		capture_select          = RUP_SEL_INFO1;
		shift_data_in           = 1'b0;
		fabric_reconfig_request = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n)
		begin
			#15 upgrade_shift_clock = 1'b1;
			#15 upgrade_shift_clock = 1'b0;
		end
	endtask : tick

	// Idle cycles first, since the status view only follows while the clock runs.
	task automatic read_word(input rup_capsel_type sel, output logic [`RUP_CTRL_W-1:0] w);
		tick(16);
		capture_select  = sel;
		capture_request = 1'b1;
		tick(1);
		capture_request = 1'b0;
		shift_enable    = 1'b1;
		w[0]            = shift_data_out;
		for (int i = 1; i < `RUP_CTRL_W; i++)
		begin
			tick(1);
			w[i] = shift_data_out;
		end
		shift_enable = 1'b0;
	endtask : read_word

	task automatic write_update(input logic [`RUP_CTRL_W-1:0] w);
		tick(2);
		shift_enable = 1'b1;
		for (int i = 0; i < `RUP_CTRL_W; i++)
		begin
			shift_data_in = w[i];
			tick(1);
		end
		shift_enable   = 1'b0;
		update_request = 1'b1;
		tick(1);
		update_request = 1'b0;
		shift_data_in  = !shift_data_in;
		tick(12);
	endtask : write_update

	task automatic fabric_pulse();
		fabric_reconfig_request = 1'b1;
		#300 fabric_reconfig_request = 1'b0;
	endtask : fabric_pulse
endmodule : rup_user_model

// file: testbench/test_rup_status_core.sv
`timescale 1ns/1ns
`include "rup_defines.svh"

module test_rup_status_core
	import rup_pkg::*;
;
	localparam logic [1:0]   ST    = 2'h2;
	localparam logic [23:0]  FBOOT = 24'h5a_3c14;
	localparam rup_ctrl_type UPD   = '{12'h5a3, 22'h0c_1234, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
	localparam logic [23:0]  UBOOT = {UPD.boot_addr_hi, 2'h0};

	logic           sys_clk;
	logic           arst_n;
	logic           external_config_reset_pin_n;
	logic           config_error_pin_n;
	logic           crc_error_evt;
	logic           watchdog_timeout_evt;
	logic           load_done;
	logic [1:0]     msm_state;
	logic [23:0]    factory_boot_addr;
	logic           upgrade_shift_clock;
	logic           fabric_reconfig_request;
	logic           shift_enable;
	logic           capture_request;
	logic           update_request;
	rup_capsel_type capture_select;
	logic           shift_data_in;
	logic           shift_data_out;
	rup_ctrl_type   control_out;
	logic           reconfig_start;
	logic           app_mode;
	logic [4:0]     last_cause;
	int             failures;
	int             n_compared;
	int             cycles;

	rup_status_core dut (.sys_clk, .arst_n, .upgrade_shift_clock, .external_config_reset_pin_n,
		.config_error_pin_n, .crc_error_evt, .watchdog_timeout_evt, .load_done, .msm_state,
		.factory_boot_addr, .fabric_reconfig_request, .shift_enable, .capture_request,
		.update_request, .capture_select, .shift_data_in, .shift_data_out, .control_out,
		.reconfig_start, .app_mode, .last_cause);
	rup_user_model u_user (.upgrade_shift_clock, .shift_enable, .capture_request,
		.update_request, .capture_select, .shift_data_in, .fabric_reconfig_request,
		.shift_data_out);

	always #25 sys_clk = !sys_clk;

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [38:0] seen, input logic [38:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	function automatic logic [38:0] prev(input logic [4:0] src);
		return {8'h00, src, ST, UBOOT};
	endfunction : prev

	// Bits of src: 4 reset pin, 3 crc, 2 error pin, 1 watchdog, 0 fabric request.
	task automatic fire(input logic [4:0] src, input logic [4:0] exp);
		if (src[0])
			fork
				u_user.fabric_pulse();
			join_none
		@(negedge sys_clk);
		external_config_reset_pin_n = !src[4];
		config_error_pin_n          = !src[2];
		crc_error_evt               = src[3];
		watchdog_timeout_evt        = src[1];
		@(negedge sys_clk);
		crc_error_evt        = 1'b0;
		watchdog_timeout_evt = 1'b0;
		for (int n = 0; n < 60 && reconfig_start !== 1'b1; n++)
			@(posedge sys_clk) #1;
		chk("reconfig_start", 39'(reconfig_start), 39'h1);
		chk("last_cause", 39'(last_cause), 39'(exp));
		chk("control_out", control_out, exp[0] ? 39'(UPD) : 39'h0);
		@(negedge sys_clk);
		external_config_reset_pin_n = 1'b1;
		config_error_pin_n          = 1'b1;
		load_done                   = 1'b1;
		@(negedge sys_clk);
		load_done = 1'b0;
		@(negedge sys_clk);
		chk("app_mode", 39'(app_mode), 39'(exp[0]));
	endtask : fire

	task automatic t_factory();
		logic [38:0] w;
		chk("app_mode", 39'(app_mode), 39'h0);
		for (int s = 0; s < 6; s++)
			if (s != 4)
			begin
				u_user.read_word(rup_capsel_type'(s), w);
				chk("capture", w, s < 2 ? {7'h00, ST, 6'h00, FBOOT} : `RUP_BAD_CAPTURE);
			end
		$display("t_factory done");
	endtask : t_factory

	task automatic t_fabric();
		logic [38:0] w;
		u_user.write_update(UPD);
		u_user.read_word(RUP_SEL_CONFIG, w);
		chk("update", w, 39'(UPD));
		fire(5'h01, 5'h01);
		$display("t_fabric done");
	endtask : t_fabric

	task automatic t_app();
		logic [38:0] w;
		u_user.read_word(RUP_SEL_INFO1, w);
		chk("info1", w, {7'h00, ST, UPD.watchdog_enable, UPD.watchdog_timer,
			`RUP_DOG_LO});
		u_user.read_word(RUP_SEL_INFO2, w);
		chk("info2", w, {7'h00, ST, 6'h00, UBOOT});
		u_user.write_update(~39'(UPD));
		u_user.read_word(RUP_SEL_CONFIG, w);
		chk("control", w, 39'(UPD));
		$display("t_app done");
	endtask : t_app

	task automatic t_causes();
		logic [38:0] w;
		fire(5'h0a, 5'h08);
		u_user.read_word(RUP_SEL_CONFIG, w);
		chk("update", w, 39'(UPD));
		u_user.read_word(RUP_SEL_PREV1, w);
		chk("prev1", w, prev(5'h08));
		u_user.read_word(RUP_SEL_PREV2, w);
		chk("prev2", w, `RUP_BAD_CAPTURE);
		fire(5'h04, 5'h04);
		fire(5'h02, 5'h02);
		fire(5'h01, 5'h01);
		fire(5'h14, 5'h10);
		u_user.read_word(RUP_SEL_PREV1, w);
		chk("prev1", w, prev(5'h10));
		u_user.read_word(RUP_SEL_PREV2, w);
		chk("prev2", w, prev(5'h08));
		$display("t_causes done");
	endtask : t_causes

	task automatic end_of_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		sys_clk                     = 1'b0;
		arst_n                      = 1'b1;
		external_config_reset_pin_n = 1'b1;
		config_error_pin_n          = 1'b1;
		crc_error_evt               = 1'b0;
		watchdog_timeout_evt        = 1'b0;
		load_done                   = 1'b0;
		msm_state                   = ST;
		factory_boot_addr           = FBOOT;
		failures                    = 0;
		n_compared                  = 0;
		cycles                      = 0;
		// Start high so that the fall is a real edge for every asynchronous reset.
		#1 arst_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_factory();
		t_fabric();
		t_app();
		t_causes();
		end_of_test();
	end
endmodule : test_rup_status_core
